/* File: rtl/swe_sleep_wake.sv */
module swe_sleep_wake
  import swe_pkg::*;
#(
  parameter int unsigned WAKE_CYC = WAKE_CYCLES,
  parameter int unsigned RST_HOLD_CYC = RST_HOLD_CYCLES
) (
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // pins from host
  input wire logic wake_pin_in,
  input wire logic reset_pin_in,
  input wire logic uart_rx_pin_in,
  // configuration write results, same clock
  input wire logic cfg_wr_in,
  input wire logic cfg_deep_sleep_in,
  input wire logic cfg_ack_mask_in,
  input wire logic cfg_rst_mask_in,
  // commands, one-cycle pulses, same clock
  input wire logic sat_ack_read_cmd_in,
  input wire logic sat_ack_clear_cmd_in,
  input wire logic reset_event_clear_cmd_in,
  // radio and queue status, same clock
  input wire logic msg_ack_event_in,
  input wire logic queue_empty_in,
  input wire logic ack_pending_in,
  input wire logic work_pending_in,
  input wire logic sat_search_in,
  input wire logic sat_contact_in,
  // outputs
  output logic event_notify_out,
  output logic antenna_busy_out,
  output logic uart_ready_out,
  output logic sleep_out,
  output logic deep_sleep_out,
  output logic queue_flush_out,
  output logic deep_sleep_sel_out
);
  typedef struct packed {
    swe_pwr_e pwr;
    logic deep_sel;
    logic ack_mask;
    logic rst_mask;
    logic ack_ev;
    logic ack_read_seen;
    logic rst_ev;
    logic rst_prev;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic notify;
    logic ant;
    logic uart_rdy;
    logic flush;
    logic slp;
    logic deep;
  } swe_state_s;

  swe_state_s st_q;
  swe_state_s st_d;
  logic [SYNC_W-1:0] pins_sync;
  logic wake_s;
  logic rstpin_s;
  logic rx_s;
  logic rst_rise;
  logic hold_ok;

  swe_sync u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in({uart_rx_pin_in, reset_pin_in, wake_pin_in}),
    .sync_out(pins_sync)
  );

  assign wake_s = pins_sync[0];
  assign rstpin_s = pins_sync[1];
  // uart idles high; a start bit pulls it low
  assign rx_s = ~pins_sync[2];
  // edges closer than the hold time are treated as glitches
  assign hold_ok = (st_q.hold_cnt == CNT_ZERO);
  assign rst_rise = rstpin_s & ~st_q.rst_prev & hold_ok;

  function automatic logic busy_now(input logic wp, input logic srch,
                                    input logic cont, input logic rx);
    busy_now = wp | srch | cont | rx;
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.flush = 1'b0;
    if (ce_in) begin
      st_d.rst_prev = rstpin_s;
      if (rstpin_s != st_q.rst_prev) begin
        st_d.hold_cnt = CNT_W'(RST_HOLD_CYC);
      end else if (!hold_ok) begin
        st_d.hold_cnt = st_q.hold_cnt - CNT_ONE;
      end
      if (cfg_wr_in) begin
        st_d.deep_sel = cfg_deep_sleep_in;
        st_d.ack_mask = cfg_ack_mask_in;
        st_d.rst_mask = cfg_rst_mask_in;
      end
      // ack event: read then clear; a new event wins over the clear
      if (sat_ack_read_cmd_in && st_q.ack_ev) begin
        st_d.ack_read_seen = 1'b1;
      end
      if (sat_ack_clear_cmd_in && st_q.ack_read_seen) begin
        st_d.ack_ev = 1'b0;
        st_d.ack_read_seen = 1'b0;
      end
      if (msg_ack_event_in) begin
        st_d.ack_ev = 1'b1;
      end
      if (reset_event_clear_cmd_in) begin
        st_d.rst_ev = 1'b0;
      end
      case (st_q.pwr)
        SWE_ACTIVE: begin
          st_d.uart_rdy = 1'b1;
          if (!busy_now(work_pending_in, sat_search_in, sat_contact_in,
                        rx_s)) begin
            // deep only with queue drained and nothing unacknowledged
            if (st_q.deep_sel && queue_empty_in && !ack_pending_in) begin
              st_d.pwr = SWE_DEEP;
              st_d.uart_rdy = 1'b0;
            end else begin
              st_d.pwr = SWE_SLEEP;
            end
          end
        end
        SWE_SLEEP: begin
          // uart stays listening; wake is well inside one char time
          if (busy_now(work_pending_in, sat_search_in, sat_contact_in,
                       rx_s)) begin
            st_d.pwr = SWE_ACTIVE;
          end else if (st_q.deep_sel && queue_empty_in &&
                       !ack_pending_in) begin
            // queue drained while dozing: drop into deep sleep
            st_d.pwr = SWE_DEEP;
            st_d.uart_rdy = 1'b0;
          end
        end
        SWE_DEEP: begin
          st_d.uart_rdy = 1'b0;
          if (wake_s) begin
            st_d.pwr = SWE_WAKING;
            st_d.cnt = CNT_W'(WAKE_CYC - 1);
          end
        end
        SWE_WAKING, SWE_BOOT: begin
          st_d.uart_rdy = 1'b0;
          if (st_q.cnt == CNT_ZERO) begin
            st_d.pwr = SWE_ACTIVE;
            st_d.uart_rdy = 1'b1;
          end else begin
            st_d.cnt = st_q.cnt - CNT_ONE;
          end
        end
        default: begin
          st_d.pwr = SWE_BOOT;
          st_d.cnt = CNT_W'(WAKE_CYC - 1);
        end
      endcase
      if (rst_rise) begin
        st_d.pwr = SWE_BOOT;
        st_d.cnt = CNT_W'(WAKE_CYC - 1);
        st_d.uart_rdy = 1'b0;
        st_d.deep_sel = 1'b0;
        st_d.ack_mask = 1'b0;
        st_d.rst_mask = 1'b0;
        st_d.ack_ev = 1'b0;
        st_d.ack_read_seen = 1'b0;
        st_d.rst_ev = 1'b1;
        st_d.flush = 1'b1;
      end
      st_d.notify = (st_d.ack_ev & ~st_d.ack_mask) |
                    (st_d.rst_ev & ~st_d.rst_mask);
      st_d.ant = sat_search_in | sat_contact_in;
      st_d.slp = (st_d.pwr == SWE_SLEEP);
      st_d.deep = (st_d.pwr == SWE_DEEP);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.pwr <= SWE_BOOT;
      st_q.cnt <= CNT_W'(WAKE_CYC - 1);
      st_q.rst_ev <= 1'b1;
      st_q.notify <= 1'b1;
      st_q.flush <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign event_notify_out = st_q.notify;
  assign antenna_busy_out = st_q.ant;
  assign uart_ready_out = st_q.uart_rdy;
  assign sleep_out = st_q.slp;
  assign deep_sleep_out = st_q.deep;
  assign queue_flush_out = st_q.flush;
  assign deep_sleep_sel_out = st_q.deep_sel;

  property p_deep_needs_drain;
    @(posedge mclk_in) disable iff (rst_in)
    (st_q.pwr != SWE_DEEP) && (st_d.pwr == SWE_DEEP) |->
      queue_empty_in && !ack_pending_in && st_q.deep_sel;
  endproperty
  a_deep_needs_drain: assert property (p_deep_needs_drain)
    else $error("deep sleep entered with queue busy");

  property p_deep_wait;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && deep_sleep_out && wake_s && !rst_rise |=> !uart_ready_out [*2];
  endproperty
  a_deep_wait: assert property (p_deep_wait)
    else $error("uart ready too early after deep wake");

  property p_deep_hold;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && deep_sleep_out && !wake_s && !rst_rise |=>
      deep_sleep_out && !uart_ready_out;
  endproperty
  a_deep_hold: assert property (p_deep_hold)
    else $error("left deep sleep without wake pin");

  property p_wake_bound;
    @(posedge mclk_in) disable iff (rst_in)
    (st_q.pwr == SWE_WAKING) && ce_in && (st_q.cnt == CNT_ZERO) &&
      !rst_rise |=> uart_ready_out;
  endproperty
  a_wake_bound: assert property (p_wake_bound)
    else $error("uart not ready at end of wake time");

  property p_boot_bound;
    @(posedge mclk_in) disable iff (rst_in)
    (st_q.pwr == SWE_BOOT) && ce_in && (st_q.cnt == CNT_ZERO) &&
      !rst_rise |=> uart_ready_out;
  endproperty
  a_boot_bound: assert property (p_boot_bound)
    else $error("uart not ready at end of boot time");

  property p_notify_rise;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && msg_ack_event_in && !st_q.ack_mask && !rst_rise &&
      !(cfg_wr_in && cfg_ack_mask_in) |=> event_notify_out;
  endproperty
  a_notify_rise: assert property (p_notify_rise)
    else $error("event pin missed ack event");

  property p_notify_fall;
    @(posedge mclk_in) disable iff (rst_in)
    $fell(event_notify_out) |->
      !(st_q.ack_ev && !st_q.ack_mask) && !(st_q.rst_ev && !st_q.rst_mask) &&
      ($past(sat_ack_clear_cmd_in) || $past(reset_event_clear_cmd_in) ||
       $past(cfg_wr_in));
  endproperty
  a_notify_fall: assert property (p_notify_fall)
    else $error("event pin fell with event pending");

  property p_ack_mask;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && st_q.ack_mask && !st_q.rst_ev && !cfg_wr_in && !rst_rise |=>
      !event_notify_out;
  endproperty
  a_ack_mask: assert property (p_ack_mask)
    else $error("masked ack event reached event pin");

  property p_ack_clear;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && sat_ack_clear_cmd_in && st_q.ack_read_seen &&
      !msg_ack_event_in |=> !st_q.ack_ev;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("ack event not cleared");

  property p_rst_clear;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && reset_event_clear_cmd_in && !rst_rise |=> !st_q.rst_ev;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("reset event not cleared");

  property p_reset_edge;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && rst_rise |=> queue_flush_out && !deep_sleep_sel_out ##1
      !queue_flush_out;
  endproperty
  a_reset_edge: assert property (p_reset_edge)
    else $error("reset edge did not flush");

  property p_flush_once;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && queue_flush_out && !rst_rise |=> !queue_flush_out;
  endproperty
  a_flush_once: assert property (p_flush_once)
    else $error("queue flush longer than one cycle");

  property p_antenna;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && (sat_search_in || sat_contact_in) |=> antenna_busy_out;
  endproperty
  a_antenna: assert property (p_antenna)
    else $error("antenna busy low during use");

  property p_sleep_wake;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && sleep_out && rx_s && !rst_rise |=> uart_ready_out && !sleep_out;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("no wake on uart traffic");
endmodule

/* File: rtl/swe_sync.sv */
module swe_sync
  import swe_pkg::*;
(
  // clock
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // async levels in, synced out
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);
  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } swe_sync_s;

  swe_sync_s st_q;
  swe_sync_s st_d;

  always_comb begin
    st_d = st_q;
    if (ce_in) begin
      st_d.meta = async_in;
      st_d.stable = st_q.meta;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;
endmodule

/* File: shared/swe_pkg.sv */
// Operation
// - one config bit picks sleep mode: 0 ordinary sleep, 1 deep sleep.
// - default config uses ordinary sleep, entered automatically whenever idle.
// - ordinary sleep wakes on uart traffic and accepts characters, no wake pin.
// - host raises wake pin; uart usable only after deep wake time.
// - deep sleep entered only when queue sent and acknowledged; else ordinary.
// - reset returns to ordinary sleep behaviour and flushes the transmit queue.
// - deleting queued messages may not reach deep sleep; pending ack blocks it.
// - event output goes high whenever an unmasked event is raised.
// - event output falls only when every pending event cleared or masked.
// - ack event cleared by ack-read then ack-clear command.
// - ack pin mask set by config write keeps ack events off output.
// - reset event cleared by its clear command; masked by reset pin mask.
// - antenna busy output high while device occupies shared antenna.
// - antenna busy held through search phases and contact phase.
// - reset begins on rising edge of reset input, not on level.
// - uart usable at most 350 ms after wake raised from deep sleep; code takes 350 ms plus 2 to 3 clock cycles.
// - uart ready at most 350 ms after a reset; after a reset pin edge the code takes 350 ms plus 2 to 3 clock cycles.
package swe_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned WAKE_MAX_MS = 350;
  // longest time rounds down
  localparam int unsigned WAKE_CYCLES = WAKE_MAX_MS * 1000 * CLK_MHZ;
  localparam int unsigned RST_HOLD_MS = 1;
  localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 27;
  localparam logic [CNT_W-1:0] CNT_ZERO = 27'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 27'h1;
  localparam int unsigned SYNC_W = 3;

  typedef enum logic [4:0] {
    SWE_ACTIVE = 5'h01,
    SWE_SLEEP  = 5'h02,
    SWE_DEEP   = 5'h04,
    SWE_WAKING = 5'h08,
    SWE_BOOT   = 5'h10
  } swe_pwr_e;
endpackage

/* File: test/sleep_wake_event_pins_tb.sv */
module sleep_wake_event_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swe_pkg::*;
  localparam int WC = 20;
  localparam int RH = 4;
  localparam int EV = 0, ANT = 1, RDY = 2, SLP = 3, DEEP = 4, SEL = 5, FL = 6;
  typedef struct {int idx; logic val; int lat;} swe_note_s;
  swe_note_s q[$];
  swe_note_s n;
  logic mclk_in = 1'h0, rst_in = 1'h1, ce = 1'h1;
  logic wake_req, reset_req, rx, cfg_wr, cfg_deep, cfg_ack_m, cfg_rst_m;
  logic ack_rd, ack_clr, rst_clr, ack_ev, q_empty, ack_pend, work;
  logic search, contact, wake_pin, reset_pin, flush_seen, flush_clr;
  logic [1:0] r;
  wire logic ev_o, ant_o, rdy_o, slp_o, deep_o, flush_o, sel_o;
  wire logic [6:0] obs = {flush_seen, sel_o, deep_o, slp_o, rdy_o, ant_o,
                          ev_o};
  int mismatches = 0;
  int samples_checked = 0;

  always #2.5 mclk_in = ~mclk_in;
  // flush is a one-cycle pulse, so latch it for the watcher
  always @(posedge mclk_in) begin
    if (flush_o === 1'h1) begin
      flush_seen <= 1'h1;
    end else if (flush_clr) begin
      flush_seen <= 1'h0;
    end
  end

  swe_host_model #(.HOLD(RH + 1)) u_host (.mclk_in(mclk_in),
    .wake_req_in(wake_req), .reset_req_in(reset_req), .uart_ready_in(rdy_o),
    .wake_pin_out(wake_pin), .reset_pin_out(reset_pin));

  swe_sleep_wake #(.WAKE_CYC(WC), .RST_HOLD_CYC(RH)) u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce),
    .wake_pin_in(wake_pin), .reset_pin_in(reset_pin), .uart_rx_pin_in(rx),
    .cfg_wr_in(cfg_wr), .cfg_deep_sleep_in(cfg_deep),
    .cfg_ack_mask_in(cfg_ack_m), .cfg_rst_mask_in(cfg_rst_m),
    .sat_ack_read_cmd_in(ack_rd), .sat_ack_clear_cmd_in(ack_clr),
    .reset_event_clear_cmd_in(rst_clr), .msg_ack_event_in(ack_ev),
    .queue_empty_in(q_empty), .ack_pending_in(ack_pend),
    .work_pending_in(work), .sat_search_in(search),
    .sat_contact_in(contact), .event_notify_out(ev_o),
    .antenna_busy_out(ant_o), .uart_ready_out(rdy_o), .sleep_out(slp_o),
    .deep_sleep_out(deep_o), .queue_flush_out(flush_o),
    .deep_sleep_sel_out(sel_o));

  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  task automatic note(input int idx, input logic val, input int lat);
    q.push_back('{idx, val, lat});
    tick(lat);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  task automatic cfg(input logic d, input logic a, input logic m);
    cfg_deep = d;
    cfg_ack_m = a;
    cfg_rst_m = m;
    pulse(cfg_wr);
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial forever begin
    wait (q.size() != 0);
    n = q.pop_front();
    repeat (n.lat) @(posedge mclk_in);
    #1;
    cmp_bit(obs[n.idx], n.val);
  end

  initial begin
    #20us;
    mismatches++;
    end_of_test();
  end

  initial begin
    {wake_req, reset_req, cfg_wr, cfg_deep, cfg_ack_m, cfg_rst_m} = '0;
    {ack_rd, ack_clr, rst_clr, ack_ev, ack_pend, work, search, contact} = '0;
    {rx, q_empty, flush_clr} = 3'h6;
    void'($urandom(39712));
    tick(12);
    rst_in = 1'h0;
    note(EV, 1'h1, 1);
    note(FL, 1'h1, 1);
    note(SEL, 1'h0, 1);
    note(RDY, 1'h0, WC - 6);
    note(RDY, 1'h1, 10);
    pulse(rst_clr);
    note(EV, 1'h0, 1);
    pulse(ack_ev);
    note(EV, 1'h1, 1);
    pulse(ack_clr);
    note(EV, 1'h1, 1);
    pulse(ack_rd);
    pulse(ack_clr);
    note(EV, 1'h0, 1);
    cfg(1'h0, 1'h1, 1'h0);
    pulse(ack_ev);
    note(EV, 1'h0, 2);
    pulse(ack_rd);
    pulse(ack_clr);
    cfg(1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 8; i++) begin
      r = 2'($urandom());
      {search, contact} = r;
      note(ANT, r[0] | r[1], 1);
    end
    {search, contact} = 2'h0;
    note(SLP, 1'h1, 8);
    note(DEEP, 1'h0, 1);
    rx = 1'h0;
    note(SLP, 1'h0, 4);
    rx = 1'h1;
    q_empty = 1'h0;
    cfg(1'h1, 1'h0, 1'h0);
    note(SEL, 1'h1, 1);
    note(DEEP, 1'h0, 8);
    note(SLP, 1'h1, 1);
    q_empty = 1'h1;
    ack_pend = 1'h1;
    note(DEEP, 1'h0, 8);
    ack_pend = 1'h0;
    note(DEEP, 1'h1, 8);
    pulse(wake_req);
    wake_req = 1'h0;
    work = 1'h1;
    note(DEEP, 1'h0, 6);
    note(RDY, 1'h0, WC - 8);
    note(RDY, 1'h1, 14);
    pulse(flush_clr);
    pulse(reset_req);
    note(FL, 1'h1, RH + 8);
    note(SEL, 1'h0, 1);
    note(EV, 1'h1, 1);
    note(RDY, 1'h0, 1);
    pulse(flush_clr);
    note(RDY, 1'h1, WC + 4);
    note(FL, 1'h0, 1);
    cfg(1'h0, 1'h0, 1'h1);
    note(EV, 1'h0, 1);
    cfg(1'h0, 1'h0, 1'h0);
    note(EV, 1'h1, 1);
    // clock enable low must freeze the antenna flag
    ce = 1'h0;
    search = 1'h1;
    note(ANT, 1'h0, 3);
    ce = 1'h1;
    note(ANT, 1'h1, 1);
    search = 1'h0;
    // let the watcher finish its last compare first
    tick(1);
    end_of_test();
  end
endmodule

/* File: test/swe_host_model.sv */
module swe_host_model #(
  parameter int unsigned HOLD = 5
) (
  // clock
  input wire logic mclk_in,
  // requests from bench, device status
  input wire logic wake_req_in,
  input wire logic reset_req_in,
  input wire logic uart_ready_in,
  // pins to device
  output logic wake_pin_out,
  output logic reset_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wake_pin_out = 1'h0;
    reset_pin_out = 1'h0;
  end
  // wake routed to the device, so deep sleep is safe to select
  always @(posedge wake_req_in) begin
    @(posedge mclk_in);
    wake_pin_out <= 1'h1;
    @(posedge uart_ready_in);
    repeat (2) @(posedge mclk_in);
    wake_pin_out <= 1'h0;
  end
  always @(posedge reset_req_in) begin
    repeat (HOLD) @(posedge mclk_in);
    reset_pin_out <= 1'h1;
    repeat (HOLD) @(posedge mclk_in);
    reset_pin_out <= 1'h0;
  end
endmodule
